// ### bench/idm_core_model.sv
// Model of the core side: one access at a time, waits for the answer.
// Assumes it is called right after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none

module idm_core_model (
    // Clock
    input wire logic core_clk,
    // Request
    output logic req_valid,
    output idm_pkg::idm_req_t req,
    input wire logic req_ready,
    // Answer
    input wire logic rsp_valid,
    input wire idm_pkg::idm_rsp_t rsp
);
    import idm_pkg::*;
    initial begin
        req_valid = 1'h0;
        req = '0;
    end
    // One byte feeds address, index, pointer select and bit address
    task automatic run(input idm_op_t o, input logic [7:0] a,
        input logic [7:0] d, output idm_rsp_t r, output logic ok);
        idm_req_t q;
        int n;
        q = '{op: o, addr: a, reg_idx: a[2:0], ind_sel: a[0],
            bit_addr: a[6:0], data: d, bit_val: d[0]};
        req <= q;
        req_valid <= 1'h1;
        @(negedge core_clk);
        while (req_ready !== 1'h1)
            @(negedge core_clk);
        @(posedge core_clk);
        req_valid <= 1'h0;
        // Released request shows the inverse, never the stale value
        req <= idm_req_t'(~q);
        @(negedge core_clk);
        for (n = 0; rsp_valid !== 1'h1; n++)
            @(negedge core_clk);
        // Indirect accesses answer one cycle later than the rest
        ok = n == ((o == IDM_OP_IND_RD || o == IDM_OP_IND_WR) ? 1 : 0);
        r = rsp;
        @(posedge core_clk);
    endtask
endmodule // idm_core_model
`default_nettype wire

// ### bench/idm_regs_monitor.sv
// Checker for the core port, stack pointer and bank select.
// Assumes it is bound to idm_regs and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "idm_defs.svh"

module idm_regs_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Core port
    input wire logic req_valid,
    input wire idm_pkg::idm_req_t req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire idm_pkg::idm_rsp_t rsp,
    // State
    input wire logic s_axi_bvalid,
    input wire logic [`IDM_BANK_W-1:0] active_bank,
    input wire logic [`IDM_ADDR_W-1:0] stack_pointer
);
    import idm_pkg::*;
    logic acc;
    logic ind;
    logic [2:0] bsel;
    assign acc = req_valid && req_ready;
    assign ind = req.op == IDM_OP_IND_RD || req.op == IDM_OP_IND_WR;
    assign bsel = req.bit_addr[2:0];
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    sequence s_ind_acc;
        acc && ind;
    endsequence
    sequence s_ind_exec;
        !req_ready ##1 rsp_valid;
    endsequence
    a_ind_two_step: assert property (s_ind_acc |=> s_ind_exec)
        else $error("indirect access not answered in two cycles");
    a_plain_answer: assert property (acc && !ind |=> rsp_valid)
        else $error("access not answered next cycle");
    a_push_sp_up: assert property (acc && req.op == IDM_OP_PUSH
        |=> stack_pointer == $past(stack_pointer) + 8'h01)
        else $error("push did not raise the pointer by one");
    a_push_echo: assert property (acc && req.op == IDM_OP_PUSH
        |=> rsp.data == $past(req.data))
        else $error("push answer differs from pushed byte");
    a_pop_sp_down: assert property (acc && req.op == IDM_OP_POP
        |=> stack_pointer == $past(stack_pointer) - 8'h01)
        else $error("pop did not lower the pointer by one");
    a_sp_reset_val: assert property ($rose(resetn)
        |-> stack_pointer == 8'h07)
        else $error("pointer not at its reset place");
    a_bit_pick: assert property (acc && req.op == IDM_OP_BIT_RD
        |=> rsp.bit_val == rsp.data[$past(bsel)])
        else $error("bit answer not the addressed bit");
    a_bank_by_bus: assert property ($changed(active_bank)
        |-> $rose(s_axi_bvalid))
        else $error("bank changed without a status word write");
endmodule // idm_regs_monitor

bind idm_regs idm_regs_monitor idm_regs_monitor_inst (
    .core_clk(core_clk), .resetn(resetn), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .s_axi_bvalid(s_axi_bvalid), .active_bank(active_bank),
    .stack_pointer(stack_pointer));
`default_nettype wire

// ### bench/idm_regs_test.sv
// Self-checking bench: register bus master tasks and core accesses.
// Assumes the block answers well inside the cycle ceiling.
`timescale 1ns/1ns
`default_nettype none

module idm_regs_test;
    import idm_pkg::*;
    logic core_clk = 1'h0;
    logic resetn = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic req_valid, req_ready, rsp_valid;
    logic [1:0] bresp, rresp, active_bank;
    logic [7:0] stack_pointer;
    idm_req_t req;
    idm_rsp_t rsp, lr;
    int fail_count = 0, n_tests = 0, cyc = 0;
    always #10 core_clk = ~core_clk;
    idm_regs idm_regs_inst (.core_clk(core_clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .active_bank(active_bank),
        .stack_pointer(stack_pointer));
    idm_core_model idm_core_model_inst (.core_clk(core_clk),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp(rsp));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up;
        end
    end
    task automatic chk(input string s, input logic [7:0] e,
        input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    // Both halves offered together; each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
        input logic [1:0] e);
        logic ta, tw, tb;
        tb = 1'h0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!tb) begin
            @(negedge core_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid === 1'h1;
            if (tb) chk("bresp", {6'h0, e}, {6'h0, bresp});
            @(posedge core_clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        // Let an edge pass so a following call never reassigns bready
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e,
        input logic [1:0] er);
        logic ta, tr;
        tr = 1'h0;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!tr) begin
            @(negedge core_clk);
            ta = arvalid && arready;
            tr = rvalid === 1'h1;
            if (tr) chk("rresp", {6'h0, er}, {6'h0, rresp});
            if (tr) chk("rdata", e, rdata[7:0]);
            @(posedge core_clk);
            if (ta) arvalid <= 1'h0;
        end
        rready <= 1'h0;
        @(posedge core_clk);
    endtask
    task automatic cw(input idm_op_t o, input logic [7:0] a,
        input logic [7:0] d);
        logic ok;
        idm_core_model_inst.run(o, a, d, lr, ok);
        chk("rsp_valid", 8'h01, {7'h0, ok});
    endtask
    task automatic cr(input idm_op_t o, input logic [7:0] a,
        input logic [7:0] e);
        cw(o, a, 8'h00);
        if (o == IDM_OP_BIT_RD) chk("bit", e, {7'h0, lr.bit_val});
        else chk("data", e, lr.data);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'h1;
        @(posedge core_clk);
        chk("sp", 8'h07, stack_pointer);
        rd(4'h4, 8'h07, 2'h0);
        rd(4'h0, 8'h00, 2'h0);
        cw(IDM_OP_PUSH, 8'h00, 8'h11);
        cr(IDM_OP_DIR_RD, 8'h08, 8'h11);
        cw(IDM_OP_PUSH, 8'h00, 8'h22);
        chk("sp", 8'h09, stack_pointer);
        cr(IDM_OP_POP, 8'h00, 8'h22);
        cr(IDM_OP_POP, 8'h00, 8'h11);
        chk("sp", 8'h07, stack_pointer);
        // Stack moved clear of the banks, then across the wrap
        wr(4'h4, 8'hff, 2'h0);
        cw(IDM_OP_PUSH, 8'h00, 8'h77);
        chk("sp", 8'h00, stack_pointer);
        cr(IDM_OP_POP, 8'h00, 8'h77);
        chk("sp", 8'hff, stack_pointer);
        for (int b = 0; b < 4; b++) begin
            wr(4'h0, 8'(b << 3), 2'h0);
            chk("bank", 8'(b), {6'h0, active_bank});
            cw(IDM_OP_REG_WR, 8'h00, 8'(8'h30 + b));
            cw(IDM_OP_REG_WR, 8'h07, 8'(8'h40 + b));
        end
        for (int b = 0; b < 4; b++) begin
            cr(IDM_OP_DIR_RD, 8'(b * 8), 8'(8'h30 + b));
            cr(IDM_OP_DIR_RD, 8'(b * 8 + 7), 8'(8'h40 + b));
        end
        wr(4'h0, 8'h10, 2'h0);
        rd(4'h0, 8'h10, 2'h0);
        rd(4'h8, 8'h02, 2'h0);
        cr(IDM_OP_REG_RD, 8'h07, 8'h42);
        cw(IDM_OP_DIR_WR, 8'h32, 8'h5c);
        cr(IDM_OP_IND_RD, 8'h00, 8'h5c);
        cw(IDM_OP_REG_WR, 8'h01, 8'h3a);
        cw(IDM_OP_IND_WR, 8'h01, 8'ha5);
        cr(IDM_OP_DIR_RD, 8'h3a, 8'ha5);
        cw(IDM_OP_DIR_WR, 8'h20, 8'h00);
        cw(IDM_OP_DIR_WR, 8'h2f, 8'h00);
        cw(IDM_OP_DIR_WR, 8'h22, 8'hff);
        cw(IDM_OP_BIT_WR, 8'h00, 8'h01);
        cw(IDM_OP_BIT_WR, 8'h07, 8'h01);
        cw(IDM_OP_BIT_WR, 8'h7f, 8'h01);
        cw(IDM_OP_BIT_WR, 8'h13, 8'h00);
        cr(IDM_OP_DIR_RD, 8'h20, 8'h81);
        cr(IDM_OP_DIR_RD, 8'h2f, 8'h80);
        cr(IDM_OP_DIR_RD, 8'h22, 8'hf7);
        cr(IDM_OP_BIT_RD, 8'h7f, 8'h01);
        cr(IDM_OP_BIT_RD, 8'h7e, 8'h00);
        wr(4'hc, 8'h55, 2'h2);
        rd(4'hc, 8'h00, 2'h2);
        resetn <= 1'h0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'h1;
        @(posedge core_clk);
        chk("sp", 8'h07, stack_pointer);
        chk("bank", 8'h00, {6'h0, active_bank});
        wrap_up;
    end
endmodule // idm_regs_test
`default_nettype wire

// ### rtl/idm_axil.sv
// AXI4-Lite slave front end: turns bus transfers into one-cycle
// register write and read strobes.
// Assumes the owner decodes addresses combinationally.
`timescale 1ns/1ns
`default_nettype none
`include "idm_defs.svh"

module idm_axil #(
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Write address and data
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register side
    output logic wr_en,
    output logic [AW-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_en,
    output logic [AW-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);

    logic aw_held_r;
    logic w_held_r;

    // Both readies stay low until the response leaves, so a second
    // write cannot slip in before bready.
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign wr_en = aw_held_r && w_held_r;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_en = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            aw_held_r <= 1'b0;
            wr_addr <= '0;
        end else if (wr_en) begin
            aw_held_r <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            w_held_r <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (wr_en) begin
            w_held_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IDM_RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `IDM_RESP_OKAY : `IDM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `IDM_ZERO32;
            s_axi_rresp <= `IDM_RESP_OKAY;
        end else if (rd_en) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ok ? rd_data : `IDM_ZERO32;
            s_axi_rresp <= rd_ok ? `IDM_RESP_OKAY : `IDM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // idm_axil

`default_nettype wire

// ### rtl/idm_defs.svh
// Constants for the internal data memory block: widths, reset values,
// field positions and register offsets.
// Assumes inclusion by bare name from rtl/.
`ifndef IDM_DEFS_SVH
`define IDM_DEFS_SVH

`define IDM_ADDR_W 8
`define IDM_DATA_W 8
`define IDM_REG_IDX_W 3
`define IDM_BIT_ADDR_W 7
`define IDM_BANK_W 2

`define IDM_SP_RESET 8'h07
`define IDM_PSW_RESET 8'h00
`define IDM_PSW_BANK_LO 3
`define IDM_PSW_BANK_HI 4

// Bit-addressable bytes sit at 0x20..0x2f: upper nibble fixed
`define IDM_BIT_BYTE_HI 4'h2
`define IDM_BIT_BYTE_LSB 3
`define IDM_PTR_PAD 2'b00
`define IDM_ONE 8'h01

`define IDM_AXI_AW 4
`define IDM_OFF_PSW 4'h0
`define IDM_OFF_SP 4'h4
`define IDM_OFF_STAT 4'h8
`define IDM_STAT_BUSY 2
`define IDM_RESP_OKAY 2'b00
`define IDM_RESP_SLVERR 2'b10
`define IDM_ZERO32 32'h0000_0000
`define IDM_ZERO8 8'h00

`endif

// ### rtl/idm_pkg.sv
// Types shared by the internal data memory block.
// Assumes idm_defs.svh is on the include path.
`include "idm_defs.svh"

package idm_pkg;

    typedef enum logic [3:0] {
        IDM_OP_DIR_RD = 4'h0,
        IDM_OP_DIR_WR = 4'h1,
        IDM_OP_REG_RD = 4'h2,
        IDM_OP_REG_WR = 4'h3,
        IDM_OP_IND_RD = 4'h4,
        IDM_OP_IND_WR = 4'h5,
        IDM_OP_BIT_RD = 4'h6,
        IDM_OP_BIT_WR = 4'h7,
        IDM_OP_PUSH = 4'h8,
        IDM_OP_POP = 4'h9
    } idm_op_t;

    typedef enum logic [0:0] {
        IDM_ST_IDLE = 1'b0,
        IDM_ST_IND = 1'b1
    } idm_state_t;

    typedef struct packed {
        idm_op_t op;
        logic [`IDM_ADDR_W-1:0] addr;
        logic [`IDM_REG_IDX_W-1:0] reg_idx;
        logic ind_sel;
        logic [`IDM_BIT_ADDR_W-1:0] bit_addr;
        logic [`IDM_DATA_W-1:0] data;
        logic bit_val;
    } idm_req_t;

    typedef struct packed {
        logic [`IDM_DATA_W-1:0] data;
        logic bit_val;
    } idm_rsp_t;

endpackage

// ### rtl/idm_ram.sv
// Byte-wide data memory array with one write port and two
// combinational read ports.
// Assumes a single clock; contents are undefined after power-up.
`timescale 1ns/1ns
`default_nettype none

module idm_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // Clock
    input wire logic core_clk,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // Read ports
    input wire logic [AW-1:0] raddr_a,
    output logic [DW-1:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [DW-1:0] rdata_b
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

endmodule // idm_ram

`default_nettype wire

// ### rtl/idm_regs.sv
// Lower internal data memory: banked working registers, bit region,
// stack with its pointer, and the register bus for the status word.
// Assumes the core holds a request stable until req_ready, and that
// software reaches the status word and stack pointer over AXI4-Lite.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "idm_defs.svh"

module idm_regs #(
    parameter int AXI_AW = `IDM_AXI_AW
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // AXI4-Lite write address and data
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Core access request
    input wire logic req_valid,
    input wire idm_pkg::idm_req_t req,
    output logic req_ready,
    // Core access answer
    output logic rsp_valid,
    output idm_pkg::idm_rsp_t rsp,
    // State seen by the core
    output logic [`IDM_BANK_W-1:0] active_bank,
    output logic [`IDM_ADDR_W-1:0] stack_pointer
);

    import idm_pkg::*;

    localparam int AW = `IDM_ADDR_W;
    localparam int DW = `IDM_DATA_W;

    idm_state_t state_r;
    idm_state_t state_nxt;
    idm_req_t held_r;
    idm_req_t exec_req;
    logic exec_go;
    logic [DW-1:0] program_status_word_r;
    logic [AW-1:0] stack_pointer_r;
    logic [AW-1:0] stack_pointer_nxt;
    logic [AW-1:0] ptr_r;
    logic [`IDM_BANK_W-1:0] bank;
    logic [AW-1:0] wreg_addr;
    logic [AW-1:0] ptr_addr;
    logic [AW-1:0] bit_byte_addr;
    logic [2:0] bit_pos;
    logic mem_we;
    logic [AW-1:0] mem_waddr;
    logic [DW-1:0] mem_wdata;
    logic [AW-1:0] mem_raddr_b;
    logic [DW-1:0] ptr_data;
    logic [DW-1:0] rd_byte;
    logic [DW-1:0] bit_merged;
    logic is_ind;

    // Register bus strobes
    logic wr_en;
    logic [AXI_AW-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_en;
    logic [AXI_AW-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic psw_wr;
    logic sp_wr;

    // Address formation

    assign bank = {program_status_word_r[`IDM_PSW_BANK_HI],
                   program_status_word_r[`IDM_PSW_BANK_LO]};
    assign active_bank = bank;
    assign stack_pointer = stack_pointer_r;

    // Bank index on top, register number below: banks stack upward
    // from address zero and no index can leave the selected bank.
    assign wreg_addr = {{(AW - `IDM_BANK_W - `IDM_REG_IDX_W){1'b0}},
                        bank, exec_req.reg_idx};

    // Pointer register is register zero or one of the active bank only
    assign ptr_addr = {{(AW - `IDM_BANK_W - `IDM_REG_IDX_W){1'b0}},
                       bank, `IDM_PTR_PAD, req.ind_sel};

    assign bit_byte_addr = {`IDM_BIT_BYTE_HI,
        exec_req.bit_addr[`IDM_BIT_ADDR_W-1:`IDM_BIT_BYTE_LSB]};
    assign bit_pos = exec_req.bit_addr[`IDM_BIT_BYTE_LSB-1:0];

    assign is_ind = (req.op == IDM_OP_IND_RD) || (req.op == IDM_OP_IND_WR);

    // Sequencing: every operation but the indirect ones completes in
    // the cycle it is accepted; indirect ones fetch the pointer first.

    assign req_ready = (state_r == IDM_ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            IDM_ST_IDLE: begin
                if (req_valid && is_ind) begin
                    state_nxt = IDM_ST_IND;
                end
            end
            IDM_ST_IND: begin
                state_nxt = IDM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= IDM_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            held_r <= '0;
            ptr_r <= '0;
        end else if (req_valid && req_ready && is_ind) begin
            held_r <= req;
            ptr_r <= ptr_data;
        end
    end

    always_comb begin
        exec_go = 1'b0;
        exec_req = req;
        if (state_r == IDM_ST_IND) begin
            exec_go = 1'b1;
            exec_req = held_r;
        end else if (req_valid && !is_ind) begin
            exec_go = 1'b1;
        end
    end

    // Single-bit write is a read-modify-write of the holding byte
    always_comb begin
        bit_merged = rd_byte;
        bit_merged[bit_pos] = exec_req.bit_val;
    end

    // Memory port steering by operation kind
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = exec_req.addr;
        mem_wdata = exec_req.data;
        mem_raddr_b = exec_req.addr;
        unique case (exec_req.op)
            IDM_OP_DIR_RD: begin
                mem_raddr_b = exec_req.addr;
            end
            IDM_OP_DIR_WR: begin
                mem_we = exec_go;
            end
            IDM_OP_REG_RD: begin
                mem_raddr_b = wreg_addr;
            end
            IDM_OP_REG_WR: begin
                mem_we = exec_go;
                mem_waddr = wreg_addr;
            end
            IDM_OP_IND_RD: begin
                mem_raddr_b = ptr_r;
            end
            IDM_OP_IND_WR: begin
                mem_we = exec_go;
                mem_waddr = ptr_r;
            end
            IDM_OP_BIT_RD: begin
                mem_raddr_b = bit_byte_addr;
            end
            IDM_OP_BIT_WR: begin
                mem_raddr_b = bit_byte_addr;
                mem_we = exec_go;
                mem_waddr = bit_byte_addr;
                mem_wdata = bit_merged;
            end
            IDM_OP_PUSH: begin
                mem_we = exec_go;
                mem_waddr = stack_pointer_r + `IDM_ONE;
            end
            IDM_OP_POP: begin
                mem_raddr_b = stack_pointer_r;
            end
            default: begin
                mem_we = 1'b0;
            end
        endcase
    end

    idm_ram #(
        .AW(AW),
        .DW(DW)
    ) u_ram (
        .core_clk(core_clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr_a(ptr_addr),
        .rdata_a(ptr_data),
        .raddr_b(mem_raddr_b),
        .rdata_b(rd_byte)
    );

    // Answer to the core, one cycle after the operation executes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= exec_go;
            if (exec_go) begin
                rsp.data <= rd_byte;
                rsp.bit_val <= rd_byte[bit_pos];
                if (exec_req.op == IDM_OP_PUSH) begin
                    rsp.data <= exec_req.data;
                end
            end
        end
    end

    // Stack pointer: eight bits, so push and pop wrap around the
    // whole memory. A bus write in the same cycle wins over the core.
    always_comb begin
        stack_pointer_nxt = stack_pointer_r;
        if (sp_wr) begin
            stack_pointer_nxt = wr_data[AW-1:0];
        end else if (exec_go && exec_req.op == IDM_OP_PUSH) begin
            stack_pointer_nxt = stack_pointer_r + `IDM_ONE;
        end else if (exec_go && exec_req.op == IDM_OP_POP) begin
            stack_pointer_nxt = stack_pointer_r - `IDM_ONE;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stack_pointer_r <= `IDM_SP_RESET;
        end else begin
            stack_pointer_r <= stack_pointer_nxt;
        end
    end

    // Changing banks mid-operation would split an indirect access
    // across two banks; the pointer is latched first, so it cannot.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            program_status_word_r <= `IDM_PSW_RESET;
        end else if (psw_wr) begin
            program_status_word_r <= wr_data[DW-1:0];
        end
    end

    // Register bus

    idm_axil #(
        .AW(AXI_AW)
    ) u_axil (
        .core_clk(core_clk),
        .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // Registers hold eight bits in byte lane zero; other lanes ignored
    assign psw_wr = wr_en && wr_strb[0] && (wr_addr == `IDM_OFF_PSW);
    assign sp_wr = wr_en && wr_strb[0] && (wr_addr == `IDM_OFF_SP);

    // Status is read-only; a write to it is accepted and dropped
    assign wr_ok = (wr_addr == `IDM_OFF_PSW) || (wr_addr == `IDM_OFF_SP) ||
                   (wr_addr == `IDM_OFF_STAT);

    always_comb begin
        rd_data = `IDM_ZERO32;
        rd_ok = 1'b1;
        unique case (rd_addr)
            `IDM_OFF_PSW: begin
                rd_data[DW-1:0] = program_status_word_r;
            end
            `IDM_OFF_SP: begin
                rd_data[AW-1:0] = stack_pointer_r;
            end
            `IDM_OFF_STAT: begin
                rd_data[`IDM_BANK_W-1:0] = bank;
                rd_data[`IDM_STAT_BUSY] = (state_r != IDM_ST_IDLE);
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // Stack placement when several banks are used is software's
    // concern; nothing here guards bank one against pushes.

endmodule // idm_regs

`default_nettype wire
